// File: rtl/pci_vme_dma_channel.sv
/*
  DMA channel between a PCI master port and a VMEbus master port through one shared queue.
  Assumes synchronous inputs, a 20 MHz clock and an arbiter that may park the PCI bus here.
*/
`timescale 1ns/100ps
`include "dma_chan_map.svh"
module pci_vme_dma_channel
  import dma_chan_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int CW    = 16
) (
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  input  wire logic          enable_in,
  input  wire logic          to_vme_in,
  input  wire logic [1:0]    aligned_burst_size_in,
  input  wire logic [1:0]    vme_width_in,
  input  wire logic [CW-1:0] tenure_byte_limit_in,
  input  wire logic [CW-1:0] backoff_interval_in,
  input  wire logic          release_on_request_in,
  input  wire logic          release_after_tenure_in,
  input  wire logic          pci_gnt_in,
  input  wire logic          pci_trdy_in,
  input  wire logic [63:0]   pci_rdata_in,
  input  wire logic          vme_grant_in,
  input  wire logic          vme_other_req_in,
  input  wire logic          vme_ack_in,
  input  wire logic [63:0]   vme_rdata_in,
  input  wire logic          pci_coupled_req_in,
  input  wire logic          posted_write_queue_full_in,
  output logic               pci_req_out,
  output logic               pci_frame_out,
  output logic               pci_irdy_out,
  output logic [63:0]        pci_wdata_out,
  output logic               vme_req_out,
  output logic               vme_busy_out,
  output logic               vme_strobe_out,
  output logic [63:0]        vme_wdata_out,
  output logic               pci_retry_out
);
  function automatic logic [3:0] beat_bytes(input logic [1:0] w);
    beat_bytes = 4'h1 << w;
  endfunction

  pci_state_t    pci_state_q;
  vme_state_t    vme_state_q;
  logic          pci_req_q, frame_q, irdy_q, vme_req_q, busy_q, strobe_q, retry_q;
  logic [63:0]   pci_wdata_q, vme_wdata_q;
  logic [4:0]    phases_q;
  logic [2:0]    gap_q;
  logic [CW-1:0] tenure_q, backoff_q;
  logic [3:0]    off_q;
  logic [63:0]   head, next_head;
  logic [3:0]    head_bytes, bb;
  logic [15:0]   level_bytes, free_bytes, entries;
  logic [4:0]    burst_phases, start_phases;
  logic          pci_ok, vme_ok, pci_beat, vme_done, expire, q_push, q_pop;

  assign bb       = beat_bytes(vme_width_in);
  assign pci_beat = (pci_state_q == P_DATA) && pci_trdy_in;
  assign vme_done = strobe_q && vme_ack_in;
  assign expire   = vme_done && ({{(CW-4){1'b0}}, bb} >= tenure_q);

  // burst size in 64-bit data phases.
  always_comb begin
    case (aligned_burst_size_in)
      `DMA_ABS_64:  burst_phases = 5'h08;
      `DMA_ABS_128: burst_phases = 5'h10;
      default:      burst_phases = 5'h04;
    endcase
  end
  // full burst unless a PCI write finds fewer entries in the queue.
  assign start_phases = (!to_vme_in && entries < {11'h000, burst_phases}) ?
                        entries[4:0] : burst_phases;
  assign pci_ok = enable_in && (to_vme_in ? free_bytes >= `DMA_PCI_WMARK_BYTES
                                          : level_bytes >= `DMA_PCI_WMARK_BYTES);
  assign vme_ok = enable_in && (to_vme_in ? level_bytes >= `DMA_VME_WMARK_BYTES
                                          : free_bytes >= `DMA_VME_WMARK_BYTES);

  // fill side and drain side sit on opposite buses.
  assign q_push = to_vme_in ? pci_beat : (vme_done && vme_state_q == V_XFER);
  assign q_pop  = to_vme_in ? (vme_done && off_q + bb >= head_bytes) : pci_beat;

  transfer_queue #(.DEPTH(DEPTH)) u_queue (
    .sys_clk_in      (sys_clk_in),
    .rst_in          (rst_in),
    .push_in         (q_push),
    .push_data_in    (to_vme_in ? pci_rdata_in : vme_rdata_in),
    .push_bytes_in   (to_vme_in ? 4'h8 : bb),
    .pop_in          (q_pop),
    .head_out        (head),
    .next_head_out   (next_head),
    .head_bytes_out  (head_bytes),
    .level_bytes_out (level_bytes),
    .free_bytes_out  (free_bytes),
    .entries_out     (entries)
  );

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pci_state_q <= P_IDLE;
      pci_req_q   <= 1'b0;
      frame_q     <= 1'b0;
      irdy_q      <= 1'b0;
      phases_q    <= 5'h00;
      gap_q       <= 3'h0;
      pci_wdata_q <= 64'h0;
    end else begin
      case (pci_state_q)
        P_IDLE: begin
          // a parked grant starts at once; otherwise request.
          if (pci_ok && pci_gnt_in && start_phases != 5'h00) begin
            pci_req_q   <= 1'b0;
            frame_q     <= 1'b1;
            phases_q    <= start_phases;
            pci_wdata_q <= head;
            pci_state_q <= P_ADDR;
          end else begin
            pci_req_q <= pci_ok && !pci_gnt_in;
          end
        end
        P_ADDR: begin
          irdy_q      <= 1'b1;
          frame_q     <= phases_q != 5'h01;
          pci_state_q <= P_DATA;
        end
        P_DATA: begin
          // IRDY stays up until the last phase completes.
          if (pci_trdy_in) begin
            phases_q    <= phases_q - 5'h01;
            pci_wdata_q <= next_head;
            frame_q     <= phases_q > 5'h02;
            if (phases_q == 5'h01) begin
              irdy_q      <= 1'b0;
              gap_q       <= 3'(`DMA_PCI_IDLE_CLKS - 1);
              pci_state_q <= P_GAP;
            end
          end
        end
        P_GAP: begin
          // six idle clocks before any new request.
          gap_q <= gap_q - 3'h1;
          if (gap_q == 3'h0) begin
            pci_state_q <= P_IDLE;
          end
        end
        default: pci_state_q <= P_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      vme_state_q <= V_IDLE;
      vme_req_q   <= 1'b0;
      busy_q      <= 1'b0;
      strobe_q    <= 1'b0;
      tenure_q    <= '0;
      backoff_q   <= '0;
      off_q       <= 4'h0;
      vme_wdata_q <= 64'h0;
    end else begin
      case (vme_state_q)
        V_IDLE: begin
          vme_req_q <= vme_ok;
          if (vme_ok) begin
            vme_state_q <= V_REQ;
          end
        end
        V_REQ: begin
          if (vme_grant_in) begin
            vme_req_q   <= 1'b0;
            busy_q      <= 1'b1;
            tenure_q    <= tenure_byte_limit_in;
            vme_state_q <= V_XFER;
          end
        end
        V_XFER: begin
          if (!strobe_q) begin
            // one beat per handshake whatever the width.
            if (enable_in && (to_vme_in ? entries != 16'h0000
                                        : free_bytes >= 16'h0008 && entries < 16'(DEPTH))) begin
              strobe_q    <= 1'b1;
              vme_wdata_q <= head >> {off_q, 3'h0};
            end else if (!enable_in || (release_on_request_in && vme_other_req_in)) begin
              busy_q      <= 1'b0;
              vme_state_q <= V_IDLE;
            end
          end else if (vme_ack_in) begin
            strobe_q <= 1'b0;
            tenure_q <= tenure_q - {{(CW-4){1'b0}}, bb};
            off_q    <= q_pop ? 4'h0 : (to_vme_in ? off_q + bb : 4'h0);
            // tenure ends on expiry even with no contender.
            if (expire) begin
              backoff_q   <= backoff_interval_in;
              vme_state_q <= V_BACKOFF;
              // early release of busy at the tenure limit.
              busy_q      <= !release_after_tenure_in;
            end
          end
        end
        V_BACKOFF: begin
          // no VME request while the backoff runs.
          busy_q    <= 1'b0;
          backoff_q <= backoff_q - 1'b1;
          if (backoff_q == '0) begin
            vme_state_q <= V_IDLE;
          end
        end
        default: vme_state_q <= V_IDLE;
      endcase
    end
  end

  // turn away, during tenure only, coupled PCI accesses aimed at the VMEbus, and any while the posted write queue is full.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      retry_q <= 1'b0;
    end else begin
      retry_q <= busy_q && (pci_coupled_req_in || posted_write_queue_full_in);
    end
  end

  assign pci_req_out    = pci_req_q;
  assign pci_frame_out  = frame_q;
  assign pci_irdy_out   = irdy_q;
  assign pci_wdata_out  = pci_wdata_q;
  assign vme_req_out    = vme_req_q;
  assign vme_busy_out   = busy_q;
  assign vme_strobe_out = strobe_q;
  assign vme_wdata_out  = vme_wdata_q;
  assign pci_retry_out  = retry_q;

  sequence s_last_phase;
    irdy_q && pci_trdy_in && phases_q == 5'h01;
  endsequence
  sequence s_quiet;
    !pci_req_q && !frame_q && !irdy_q;
  endsequence

  chk_pci_read_mark: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ($rose(pci_req_q) || $rose(frame_q)) && to_vme_in |-> $past(free_bytes) >= `DMA_PCI_WMARK_BYTES)
    else $error("PCI read started with under 128 free bytes");
  chk_pci_write_mark: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ($rose(pci_req_q) || $rose(frame_q)) && !to_vme_in |-> $past(level_bytes) >= `DMA_PCI_WMARK_BYTES)
    else $error("PCI write started with under 128 queued bytes");
  chk_vme_read_mark: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(vme_req_q) && !to_vme_in |-> $past(free_bytes) >= `DMA_VME_WMARK_BYTES)
    else $error("VME read requested with under 64 free bytes");
  chk_vme_write_mark: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(vme_req_q) && to_vme_in |-> $past(level_bytes) >= `DMA_VME_WMARK_BYTES)
    else $error("VME write requested with under 64 queued bytes");
  chk_tenure_expiry: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    expire |=> vme_state_q == V_BACKOFF && !strobe_q)
    else $error("Tenure expiry did not pause the VME side");
  chk_backoff_no_req: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    vme_state_q == V_BACKOFF |=> !vme_req_q)
    else $error("VME requested during backoff");
  chk_early_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    expire && release_after_tenure_in |=> !busy_q)
    else $error("Busy not released at tenure limit");
  chk_coupled_retry: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    busy_q && pci_coupled_req_in |=> retry_q)
    else $error("Coupled access not retried during tenure");
  chk_irdy_held: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irdy_q && !(pci_trdy_in && phases_q == 5'h01) |=> irdy_q)
    else $error("IRDY dropped before transaction end");
  chk_idle_gap: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_last_phase |=> s_quiet [*6])
    else $error("PCI activity inside six-clock gap");
  chk_req_no_gnt: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(pci_req_q) |-> !$past(pci_gnt_in))
    else $error("PCI request raised while grant present");
endmodule

// File: rtl/dma_chan_map.svh
/*
  Constants of the DMA channel: watermarks, burst sizes, idle gap and queue word size.
  Assumes it is included by bare name from the channel's design files.
*/
`ifndef DMA_CHAN_MAP_SVH
`define DMA_CHAN_MAP_SVH

`define DMA_WORD_BYTES      8
`define DMA_PCI_WMARK_BYTES 128
`define DMA_VME_WMARK_BYTES 64
`define DMA_PCI_IDLE_CLKS   6
`define DMA_ABS_32          2'h0
`define DMA_ABS_64          2'h1
`define DMA_ABS_128         2'h2
`define DMA_WIDTH_D08       2'h0
`define DMA_WIDTH_D16       2'h1
`define DMA_WIDTH_D32       2'h2
`define DMA_WIDTH_D64       2'h3

`endif

// File: rtl/dma_chan_pkg.sv
/*
  Types of the DMA channel: one-hot state encodings of the PCI and VME sides.
  Assumes nothing of its surroundings.
*/
package dma_chan_pkg;

  typedef enum logic [3:0] {
    P_IDLE = 4'h1,
    P_ADDR = 4'h2,
    P_DATA = 4'h4,
    P_GAP  = 4'h8
  } pci_state_t;

  typedef enum logic [3:0] {
    V_IDLE    = 4'h1,
    V_REQ     = 4'h2,
    V_XFER    = 4'h4,
    V_BACKOFF = 4'h8
  } vme_state_t;

endpackage

// File: rtl/transfer_queue.sv
/*
  Shared transfer queue: 64-bit entries, each tagged with its count of valid bytes.
  Assumes callers never push when full nor pop when empty.
*/
`timescale 1ns/100ps
`include "dma_chan_map.svh"
module transfer_queue #(
  parameter int DEPTH = 32
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        push_in,
  input  wire logic [63:0] push_data_in,
  input  wire logic [3:0]  push_bytes_in,
  input  wire logic        pop_in,
  output logic      [63:0] head_out,
  output logic      [63:0] next_head_out,
  output logic      [3:0]  head_bytes_out,
  output logic      [15:0] level_bytes_out,
  output logic      [15:0] free_bytes_out,
  output logic      [15:0] entries_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [15:0] CAP_BYTES = 16'(DEPTH * `DMA_WORD_BYTES);

  logic [63:0]   data_mem [DEPTH];
  logic [3:0]    bytes_mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [15:0]   level_q;
  logic [15:0]   entries_q;
  logic [15:0]   pop_bytes;
  logic [15:0]   push_bytes;

  assign head_out        = data_mem[rd_ptr_q];
  assign next_head_out   = data_mem[AW'(rd_ptr_q + 1'b1)];
  assign head_bytes_out  = bytes_mem[rd_ptr_q];
  assign level_bytes_out = level_q;
  assign free_bytes_out  = CAP_BYTES - level_q;
  assign entries_out     = entries_q;
  assign pop_bytes       = pop_in ? {12'h000, bytes_mem[rd_ptr_q]} : 16'h0000;
  assign push_bytes      = push_in ? {12'h000, push_bytes_in} : 16'h0000;

  always_ff @(posedge sys_clk_in) begin
    if (push_in) begin
      data_mem[wr_ptr_q]  <= push_data_in;
      bytes_mem[wr_ptr_q] <= push_bytes_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      level_q   <= 16'h0000;
      entries_q <= 16'h0000;
    end else begin
      if (push_in) begin
        wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
      end
      if (pop_in) begin
        rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
      end
      level_q   <= level_q + push_bytes - pop_bytes;
      entries_q <= entries_q + {15'h0000, push_in} - {15'h0000, pop_in};
    end
  end
endmodule

// File: test/dma_far_side.sv
/*
  Far side of the DMA channel: PCI target with arbiter, VME slave with arbiter.
  Assumes the channel's clock and reset, and sees the channel's pins directly.
*/
`timescale 1ns/100ps
module dma_far_side (
  input  wire logic   sys_clk_in,
  input  wire logic   rst_in,
  input  wire logic   park_in,
  input  wire logic   hold_in,
  input  wire logic   pci_req_in,
  input  wire logic   pci_irdy_in,
  input  wire logic   vme_req_in,
  input  wire logic   vme_strobe_in,
  output logic        pci_gnt_out,
  output logic        pci_trdy_out,
  output logic [63:0] pci_rdata_out,
  output logic        vme_grant_out,
  output logic        vme_ack_out,
  output logic [63:0] vme_rdata_out
);
  logic [7:0]  p_idx_q;
  logic [7:0]  v_idx_q;
  logic [1:0]  wait_q;
  logic [63:0] p_word;
  logic [63:0] v_word;
  assign p_word = 64'h1111_2222_3333_4401 + {56'h0, p_idx_q};
  assign v_word = 64'h5555_6666_7777_8801 + {56'h0, v_idx_q};
  // Idle data lines show the inverse, so a capture outside a phase cannot match.
  assign pci_rdata_out = pci_trdy_out ? p_word : ~p_word;
  assign vme_rdata_out = vme_ack_out ? v_word : ~v_word;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {pci_gnt_out, pci_trdy_out, vme_grant_out, vme_ack_out} <= 4'h0;
      {p_idx_q, v_idx_q, wait_q} <= 18'h0;
    end else begin
      pci_gnt_out <= park_in | pci_req_in;
      // A target wait every fourth clock tests that the master never stalls itself.
      wait_q <= pci_irdy_in ? wait_q + 2'h1 : 2'h0;
      pci_trdy_out <= pci_irdy_in & (wait_q != 2'h2);
      p_idx_q <= p_idx_q + {7'h0, pci_irdy_in & pci_trdy_out};
      vme_grant_out <= vme_req_in & ~hold_in;
      vme_ack_out <= vme_strobe_in & ~vme_ack_out;
      v_idx_q <= v_idx_q + {7'h0, vme_strobe_in & vme_ack_out};
    end
  end
endmodule

// File: test/pci_vme_dma_channel_tb.sv
/*
  Self-checking bench of the DMA channel: burst, watermark, tenure and retry tests.
  Assumes the far side model and a 20 MHz clock; a negedge monitor gathers figures.
*/
`timescale 1ns/100ps
module pci_vme_dma_channel_tb;
  logic        sys_clk, rst, enable, to_vme, rel_on_req, rat, other, coupled, full, park, hold;
  logic [1:0]  abs_sel, width;
  logic [15:0] limit, backoff;
  logic        gnt, trdy, vgnt, ack, req, frame, irdy, vreq, busy, strobe, retry;
  logic [63:0] rdata, vrdata, wdata, vwdata, first_vw, first_pw;
  logic        pstart, vstart, vw_seen, pb_irdy, pb_st, pb_rq, pb_gnt, pb_busy, pb_vreq, pb_cf;
  int          err_count, checks_done, ph, last_ph, tot_ph, quiet, last_gap, beats;
  int          last_beats, lag, last_lag, off, last_off, acks, tenures, retry_bad;
  int          retry_hits, req_bad, start_acks, vstart_ph, k, t0, i;
  int          bp [4] = '{4, 8, 16, 4};
  int          tp [4] = '{20, 24, 32, 20};

  pci_vme_dma_channel i_dut (.sys_clk_in(sys_clk), .rst_in(rst), .enable_in(enable),
    .to_vme_in(to_vme), .aligned_burst_size_in(abs_sel), .vme_width_in(width),
    .tenure_byte_limit_in(limit), .backoff_interval_in(backoff),
    .release_on_request_in(rel_on_req), .release_after_tenure_in(rat), .pci_gnt_in(gnt),
    .pci_trdy_in(trdy), .pci_rdata_in(rdata), .vme_grant_in(vgnt),
    .vme_other_req_in(other), .vme_ack_in(ack), .vme_rdata_in(vrdata),
    .pci_coupled_req_in(coupled), .posted_write_queue_full_in(full), .pci_req_out(req),
    .pci_frame_out(frame), .pci_irdy_out(irdy), .pci_wdata_out(wdata), .vme_req_out(vreq),
    .vme_busy_out(busy), .vme_strobe_out(strobe), .vme_wdata_out(vwdata),
    .pci_retry_out(retry));

  dma_far_side i_far (.sys_clk_in(sys_clk), .rst_in(rst), .park_in(park), .hold_in(hold),
    .pci_req_in(req), .pci_irdy_in(irdy), .vme_req_in(vreq), .vme_strobe_in(strobe),
    .pci_gnt_out(gnt), .pci_trdy_out(trdy), .pci_rdata_out(rdata), .vme_grant_out(vgnt),
    .vme_ack_out(ack), .vme_rdata_out(vrdata));

  always #25 sys_clk = ~sys_clk;

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task do_reset;
    rst = 1'b1;
    tick(3);
    {tot_ph, acks, ph, beats} = '0;
    {pstart, vstart, vw_seen} = 3'h0;
    rst = 1'b0;
  endtask

  // Figures are taken at the falling edge, where every output has settled.
  always @(negedge sys_clk) begin
    if (!rst) begin
      if (irdy & trdy) begin
        ph++;
        tot_ph++;
      end
      if (pb_irdy & !irdy) begin
        last_ph = ph;
        ph = 0;
        quiet = 0;
      end else if (!irdy & !(req | frame)) quiet++;
      if ((req | frame) & !pb_st) begin
        last_gap = quiet;
        if (!pstart) start_acks = acks;
        if (!pstart) first_pw = wdata;
        pstart = 1'b1;
      end
      if (req & !pb_rq & pb_gnt) req_bad++;
      if (strobe & ack) begin
        beats++;
        acks++;
        lag = 0;
        if (!vw_seen) first_vw = vwdata;
        vw_seen = 1'b1;
      end else if (busy) lag++;
      if (pb_busy & !busy) begin
        last_beats = beats;
        beats = 0;
        last_lag = lag;
        off = 0;
        tenures++;
      end else if (!busy & !vreq) off++;
      if (vreq & !pb_vreq) begin
        last_off = off;
        if (!vstart) vstart_ph = tot_ph;
        vstart = 1'b1;
      end
      if (retry !== (pb_busy & pb_cf)) retry_bad++;
      if (pb_busy & pb_cf) retry_hits++;
    end
    {pb_irdy, pb_st, pb_rq, pb_gnt} = {irdy, req | frame, req, gnt};
    {pb_busy, pb_vreq, pb_cf} = {busy, vreq, coupled | full};
  end

  initial begin
    {sys_clk, rst, enable, to_vme, rel_on_req, rat, other, coupled, full, park, hold} = 11'h3c1;
    {abs_sel, width} = 4'h3;
    limit = 16'h0008;
    backoff = 16'h0003;
    for (k = 0; k < 4; k++) begin
      abs_sel = k[1:0];
      park = k[0];
      do_reset();
      tick(400);
      check(last_ph, bp[k]);
      check(tot_ph, tp[k]);
      check(last_gap >= 6 && last_gap <= 8, 1);
      check(vstart_ph * 8 >= 64, 1);
      $display("burst test %0d done", k);
    end
    check(req_bad, 0);
    hold = 1'b0;
    for (k = 3; k >= 0; k--) begin
      width = k[1:0];
      rat = k[0];
      coupled = k[1];
      full = !k[1];
      t0 = tenures;
      for (i = 0; i < 4000 && tenures < t0 + 2; i++) tick(1);
      check(i < 4000, 1);
      check(last_beats, 8 >> k);
      check(last_lag, !rat);
      check(last_off + last_lag >= 4 && last_off + last_lag <= 8, 1);
      $display("tenure test width %0d done", k);
    end
    check(first_vw, 64'h1111_2222_3333_4401);
    check(retry_bad, 0);
    check(retry_hits > 0, 1);
    {to_vme, park, coupled, full} = 4'h4;
    {abs_sel, width} = 4'hb;
    limit = 16'h0040;
    do_reset();
    for (i = 0; i < 4000 && !pstart; i++) tick(1);
    check(i < 4000, 1);
    check(start_acks * 8 >= 128, 1);
    check(first_pw, 64'h5555_6666_7777_8801);
    check(vstart, 1);
    check(retry_bad, 0);
    $display("write direction test done");
    results();
  end

  // The tests need some 2000 clocks; the limit allows ten times that.
  initial begin
    #1000000;
    err_count++;
    results();
  end
endmodule
